// ===== adc_frontend_config_regs.sv
/*
  Front-end configuration register bank of a delta-sigma converter: filter,
  clock/range/reference control, bias/excitation source and input mux
  select, with decoded steering outputs and output data coding.
  Assumes the serial port and the sequencer sit on mclk and drive the
  register port with one-cycle strobes; pin sampling happens elsewhere.
*/
// Overview of operation
// - Control bit 7 picks clock source; 0 internal oscillator, 1 external via first pin.
// - External clock select set overrides the first pin's own control setting.
// - Sequencer writes to the clock select bit during a sequence are dropped.
// - Control bit 6 picks range; 1 unipolar, 0 bipolar by default.
// - Bipolar results: bit 5 high gives offset binary, low gives two's complement.
// - Unipolar results are straight binary; format bit ignored.
// - Range or format changes leave thresholds untouched; software rewrites them.
// - Out-of-range inputs saturate to minimum or maximum code of active coding.
// - Control bits 4 and 3 enable positive and negative reference buffers.
// - Control bits 2:0 pick reference pair, supply or single-ended; default 001.
// - Source bits 7:6 pick bias mode: active, 125k divider, or 20k divider.
// - Source bits 5:4 pick burnout current: off, 0.5, 1 or 10 microamps.
// - Source bits 3:0 set excitation level; codes 1100 and 1101 undefined.
// - Enabling bias on an input with excitation clears that excitation enable.
// - Enabling excitation on an input with bias clears that bias enable.
// - Filter bits 5:4 pick filter type; 50/60 Hz default, 50, 60, sinc4.
`timescale 1ns/1ps
`default_nettype none
module adc_frontend_config_regs
  import adc_cfg_pkg::*;
#(
  parameter int RES_W = 24
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_wr_seq,
  input wire logic seq_running,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic bias_wr,
  input wire logic [adc_cfg_pkg::BIAS_INPUTS-1:0] bias_wdata,
  input wire logic [adc_cfg_pkg::BIAS_INPUTS-1:0] bias_en,
  input wire logic exc_wr,
  input wire logic [7:0] exc_sel_new,
  input wire logic [7:0] exc_sel_cur,
  output logic [1:0] exc_clear,
  output logic [adc_cfg_pkg::BIAS_INPUTS-1:0] bias_clear,
  input wire logic first_gpio_control_out,
  input wire logic first_gpio_control_oe_n,
  output logic gp0_out,
  output logic gp0_oe_n,
  output logic external_clock_select,
  output logic unipolar_range_select,
  output logic ref_pos_buffer_enable,
  output logic ref_neg_buffer_enable,
  output logic [1:0] ref_pair_sel,
  output logic ref_supply,
  output logic ref_single_ended,
  output logic bias_active,
  output logic bias_div125k,
  output logic bias_div20k,
  output logic [1:0] burnout_current_level,
  output logic [3:0] excitation_current_level,
  output logic excitation_level_valid,
  output logic [adc_cfg_pkg::MUX_INPUTS-1:0] positive_mux_input,
  output logic pos_to_supply,
  output logic [adc_cfg_pkg::MUX_INPUTS-1:0] negative_mux_input,
  output logic neg_to_ground,
  output logic [1:0] filter_type_select,
  output logic [3:0] rate_select,
  input wire logic result_valid,
  input wire logic signed [RES_W+1:0] result_raw,
  output logic [RES_W-1:0] result_code,
  output logic result_code_valid
);
  logic [7:0] filter_r;
  logic [7:0] ctrl_r;
  logic [7:0] source_r;
  logic [7:0] mux_r;
  logic [7:0] ctrl_nxt;
  logic ext_clk_locked;
  logic [2:0] ref_code;
  logic [3:0] pos_code;
  logic [3:0] neg_code;
  logic [3:0] exc_code;
  logic signed [RES_W+1:0] clamped;
  logic [RES_W-1:0] code_nxt;

  // Saturation limits of each coding, as signed values at raw width
  localparam logic signed [RES_W+1:0] BI_MAX = {3'b000, {(RES_W-1){1'b1}}};
  localparam logic signed [RES_W+1:0] BI_MIN = {3'b111, {(RES_W-1){1'b0}}};
  localparam logic signed [RES_W+1:0] UNI_MAX = {2'b00, {RES_W{1'b1}}};
  localparam logic signed [RES_W+1:0] UNI_MIN = '0;

  // Clock select is frozen against sequencer writes only; a serial-port write can still switch the clock mid-run
  assign ext_clk_locked = reg_wr_seq && seq_running;

  always_comb begin
    ctrl_nxt = reg_wdata;
    if (ext_clk_locked) begin
      ctrl_nxt[EXTERNAL_CLOCK_SELECT_BIT] = ctrl_r[EXTERNAL_CLOCK_SELECT_BIT];
    end
  end

  // Filter register; reserved bits stay zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filter_r <= FILTER_RST;
    end else if (reg_wr && reg_addr == FILTER_ADDR) begin
      filter_r <= reg_wdata & FILTER_WMASK;
    end
  end

  // Control register; thresholds elsewhere are not rewritten on a format change
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (reg_wr && reg_addr == CTRL_ADDR) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Source register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      source_r <= SOURCE_RST;
    end else if (reg_wr && reg_addr == SOURCE_ADDR) begin
      source_r <= reg_wdata;
    end
  end

  // Mux register; reset leaves both inputs open
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mux_r <= MUX_RST;
    end else if (reg_wr && reg_addr == MUX_ADDR) begin
      mux_r <= reg_wdata;
    end
  end

  // Read port: data one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        FILTER_ADDR: reg_rdata <= filter_r;
        CTRL_ADDR: reg_rdata <= ctrl_r;
        SOURCE_ADDR: reg_rdata <= source_r;
        MUX_ADDR: reg_rdata <= mux_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // First pin: an external clock turns it into an input whatever its control says
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gp0_out <= 1'b0;
      gp0_oe_n <= 1'b1;
    end else if (ctrl_r[EXTERNAL_CLOCK_SELECT_BIT]) begin
      gp0_out <= 1'b0;
      gp0_oe_n <= 1'b1;
    end else begin
      gp0_out <= first_gpio_control_out;
      gp0_oe_n <= first_gpio_control_oe_n;
    end
  end

  assign ref_code = ctrl_r[REF_SEL_LSB +: 3];

  // Clock, range and reference steering
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      external_clock_select <= 1'b0;
      unipolar_range_select <= 1'b0;
      ref_pos_buffer_enable <= 1'b0;
      ref_neg_buffer_enable <= 1'b0;
      ref_pair_sel <= 2'h1;
      ref_supply <= 1'b0;
      ref_single_ended <= 1'b0;
    end else begin
      external_clock_select <= ctrl_r[EXTERNAL_CLOCK_SELECT_BIT];
      unipolar_range_select <= ctrl_r[UNIPOLAR_BIT];
      ref_pos_buffer_enable <= ctrl_r[REFP_BUF_BIT];
      ref_neg_buffer_enable <= ctrl_r[REFN_BUF_BIT];
      ref_pair_sel <= ref_code[1:0];
      ref_supply <= (ref_code == REF_SUPPLY_A) || (ref_code == REF_SUPPLY_B);
      ref_single_ended <= ref_code[2] && (ref_code != REF_SUPPLY_B);
    end
  end

  assign exc_code = source_r[EXC_LEVEL_LSB +: 4];

  // Bias, burnout and excitation level steering
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bias_active <= 1'b1;
      bias_div125k <= 1'b0;
      bias_div20k <= 1'b0;
      burnout_current_level <= 2'h0;
      excitation_current_level <= 4'h0;
      excitation_level_valid <= 1'b1;
    end else begin
      bias_active <= source_r[BIAS_MODE_LSB +: 2] == BIAS_ACTIVE;
      bias_div125k <= source_r[BIAS_MODE_LSB +: 2] == BIAS_DIV125K;
      bias_div20k <= source_r[BIAS_MODE_LSB + 1];
      burnout_current_level <= source_r[BURNOUT_LSB +: 2];
      excitation_current_level <= exc_code;
      // Undefined level codes are flagged so the analog side can hold off
      excitation_level_valid <= (exc_code != EXC_UNDEF_A) && (exc_code != EXC_UNDEF_B);
    end
  end

  assign pos_code = mux_r[POS_SEL_LSB +: 4];
  assign neg_code = mux_r[NEG_SEL_LSB +: 4];

  // Input mux steering as one-hot switch enables
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      positive_mux_input <= '0;
      pos_to_supply <= 1'b0;
      negative_mux_input <= '0;
      neg_to_ground <= 1'b0;
    end else begin
      positive_mux_input <= (pos_code < 4'(MUX_INPUTS)) ?
                            (MUX_INPUTS'(1) << pos_code) : '0;
      pos_to_supply <= pos_code == MUX_RAIL_CODE;
      negative_mux_input <= (neg_code < 4'(MUX_INPUTS)) ?
                            (MUX_INPUTS'(1) << neg_code) : '0;
      neg_to_ground <= neg_code == MUX_RAIL_CODE;
    end
  end

  // Filter steering
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filter_type_select <= 2'h0;
      rate_select <= 4'h0;
    end else begin
      filter_type_select <= filter_r[FILT_TYPE_LSB +: 2];
      rate_select <= filter_r[RATE_LSB +: 4];
    end
  end

  // Result coding: clamp to the active range, then recode
  always_comb begin
    clamped = result_raw;
    code_nxt = '0;
    if (ctrl_r[UNIPOLAR_BIT]) begin
      if (result_raw > UNI_MAX) begin
        clamped = UNI_MAX;
      end else if (result_raw < UNI_MIN) begin
        clamped = UNI_MIN;
      end
      code_nxt = clamped[RES_W-1:0];
    end else begin
      if (result_raw > BI_MAX) begin
        clamped = BI_MAX;
      end else if (result_raw < BI_MIN) begin
        clamped = BI_MIN;
      end
      code_nxt = clamped[RES_W-1:0];
      if (ctrl_r[FORMAT_BIT]) begin
        code_nxt[RES_W-1] = ~clamped[RES_W-1];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result_code <= '0;
      result_code_valid <= 1'b0;
    end else begin
      result_code_valid <= result_valid;
      if (result_valid) begin
        result_code <= code_nxt;
      end
    end
  end

  // Bias and excitation must never share an input; same-cycle writes that pick one input both pass
  bias_exc_guard #(
    .NUM_EXC(2)
  ) u_guard (
    .mclk(mclk),
    .rst_n(rst_n),
    .bias_wr(bias_wr),
    .bias_wdata(bias_wdata),
    .bias_en(bias_en),
    .exc_wr(exc_wr),
    .exc_sel_new(exc_sel_new),
    .exc_sel_cur(exc_sel_cur),
    .exc_clear(exc_clear),
    .bias_clear(bias_clear)
  );

  property p_external_clock_select_frozen;
    @(posedge mclk) disable iff (!rst_n)
      (reg_wr && reg_wr_seq && seq_running && reg_addr == CTRL_ADDR) |=>
        $stable(ctrl_r[EXTERNAL_CLOCK_SELECT_BIT]) ##1 external_clock_select == ctrl_r[EXTERNAL_CLOCK_SELECT_BIT];
  endproperty
  a_external_clock_select_frozen: assert property (p_external_clock_select_frozen) else $error("clock select changed");

  property p_ctrl_readback;
    @(posedge mclk) disable iff (!rst_n)
      (reg_wr && !reg_wr_seq && reg_addr == CTRL_ADDR) ##1 (reg_rd && !reg_wr && reg_addr == CTRL_ADDR)
        |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong");

  property p_gp0_override;
    @(posedge mclk) disable iff (!rst_n)
      ctrl_r[EXTERNAL_CLOCK_SELECT_BIT] |=> gp0_oe_n;
  endproperty
  a_gp0_override: assert property (p_gp0_override) else $error("pin driven under ext clock");

  property p_uni_floor;
    @(posedge mclk) disable iff (!rst_n)
      (result_valid && ctrl_r[UNIPOLAR_BIT] && result_raw < 0) |=> result_code == '0 && result_code_valid;
  endproperty
  a_uni_floor: assert property (p_uni_floor) else $error("unipolar floor wrong");

  property p_bi_ceiling;
    @(posedge mclk) disable iff (!rst_n)
      (result_valid && !ctrl_r[UNIPOLAR_BIT] && !ctrl_r[FORMAT_BIT] && result_raw > BI_MAX)
        |=> result_code == {1'b0, {(RES_W-1){1'b1}}};
  endproperty
  a_bi_ceiling: assert property (p_bi_ceiling) else $error("bipolar ceiling wrong");

  property p_offset_zero;
    @(posedge mclk) disable iff (!rst_n)
      (result_valid && !ctrl_r[UNIPOLAR_BIT] && ctrl_r[FORMAT_BIT] && result_raw == 0)
        |=> result_code == {1'b1, {(RES_W-1){1'b0}}};
  endproperty
  a_offset_zero: assert property (p_offset_zero) else $error("offset binary zero wrong");

  property p_ref_supply;
    @(posedge mclk) disable iff (!rst_n)
      (ref_code == REF_SUPPLY_B) |=> ref_supply && !ref_single_ended;
  endproperty
  a_ref_supply: assert property (p_ref_supply) else $error("supply reference wrong");

  property p_filter_type;
    @(posedge mclk) disable iff (!rst_n)
      (reg_wr && reg_addr == FILTER_ADDR) |=> ##1 filter_type_select == $past(reg_wdata[5:4], 2);
  endproperty
  a_filter_type: assert property (p_filter_type) else $error("filter type wrong");

  property p_neg_ground;
    @(posedge mclk) disable iff (!rst_n)
      (neg_code == MUX_RAIL_CODE) |=> neg_to_ground && negative_mux_input == '0;
  endproperty
  a_neg_ground: assert property (p_neg_ground) else $error("negative ground wrong");
endmodule // adc_frontend_config_regs
`default_nettype wire

// ===== adc_cfg_pkg.sv
/*
  Constants for the converter front-end configuration registers: register
  offsets, field positions, reset values and selection codes.
  Assumes nothing of its surroundings; imported by the register bank.
*/
`default_nettype none
package adc_cfg_pkg;
  // Register offsets on the internal register port
  localparam logic [7:0] FILTER_ADDR = 8'h08;
  localparam logic [7:0] CTRL_ADDR = 8'h09;
  localparam logic [7:0] SOURCE_ADDR = 8'h0A;
  localparam logic [7:0] MUX_ADDR = 8'h0B;

  // Reset values
  localparam logic [7:0] FILTER_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] SOURCE_RST = 8'h00;
  localparam logic [7:0] MUX_RST = 8'hFF;

  // Filter register: only filter type and rate are writable
  localparam logic [7:0] FILTER_WMASK = 8'h3F;
  localparam int FILT_TYPE_LSB = 4;
  localparam int RATE_LSB = 0;

  // Control register fields
  localparam int EXTERNAL_CLOCK_SELECT_BIT = 7;
  localparam int UNIPOLAR_BIT = 6;
  localparam int FORMAT_BIT = 5;
  localparam int REFP_BUF_BIT = 4;
  localparam int REFN_BUF_BIT = 3;
  localparam int REF_SEL_LSB = 0;

  // Reference select codes
  localparam logic [2:0] REF_SUPPLY_A = 3'h3;
  localparam logic [2:0] REF_SUPPLY_B = 3'h7;

  // Source register fields
  localparam int BIAS_MODE_LSB = 6;
  localparam int BURNOUT_LSB = 4;
  localparam int EXC_LEVEL_LSB = 0;
  localparam logic [1:0] BIAS_ACTIVE = 2'h0;
  localparam logic [1:0] BIAS_DIV125K = 2'h1;
  localparam logic [3:0] EXC_UNDEF_A = 4'hC;
  localparam logic [3:0] EXC_UNDEF_B = 4'hD;

  // Mux register fields and codes
  localparam int POS_SEL_LSB = 4;
  localparam int NEG_SEL_LSB = 0;
  localparam int MUX_INPUTS = 10;
  localparam int BIAS_INPUTS = 8;
  localparam logic [3:0] MUX_RAIL_CODE = 4'hA;
endpackage
`default_nettype wire

// ===== bias_exc_guard.sv
/*
  Guard that keeps the bias voltage source and an excitation current source
  off the same analog input, except when both writes enable that input in one cycle. Raises one-cycle clear pulses for the side that
  was already on. Assumes the bias and excitation select registers live
  outside and apply the clear pulses one cycle after the write.
*/
`timescale 1ns/1ps
`default_nettype none
module bias_exc_guard
  import adc_cfg_pkg::*;
#(
  parameter int NUM_EXC = 2
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic bias_wr,
  input wire logic [BIAS_INPUTS-1:0] bias_wdata,
  input wire logic [BIAS_INPUTS-1:0] bias_en,
  input wire logic exc_wr,
  input wire logic [4*NUM_EXC-1:0] exc_sel_new,
  input wire logic [4*NUM_EXC-1:0] exc_sel_cur,
  output logic [NUM_EXC-1:0] exc_clear,
  output logic [BIAS_INPUTS-1:0] bias_clear
);
  logic [NUM_EXC-1:0] exc_clear_nxt;
  logic [BIAS_INPUTS-1:0] bias_hit [NUM_EXC];
  logic [BIAS_INPUTS-1:0] bias_hit_any;

  // Per excitation source: check both directions of the conflict
  genvar k;
  generate
    for (k = 0; k < NUM_EXC; k++) begin : g_exc
      logic [3:0] cur;
      logic [3:0] nxt;
      assign cur = exc_sel_cur[4*k +: 4];
      assign nxt = exc_sel_new[4*k +: 4];
      // Bias newly enabled where this source already sits
      assign exc_clear_nxt[k] = bias_wr && (cur < 4'(BIAS_INPUTS)) &&
                                bias_wdata[cur[2:0]] && !bias_en[cur[2:0]];
      // Source moved onto an input that already carries bias
      assign bias_hit[k] = (exc_wr && (nxt < 4'(BIAS_INPUTS)) && bias_en[nxt[2:0]]) ?
                           (BIAS_INPUTS'(1) << nxt[2:0]) : '0;
    end
  endgenerate

  // Any source landing on a biased input clears it; holds for every source count
  always_comb begin
    bias_hit_any = '0;
    for (int j = 0; j < NUM_EXC; j++) begin
      bias_hit_any = bias_hit_any | bias_hit[j];
    end
  end

  // Clear pulses, one cycle wide
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      exc_clear <= '0;
      bias_clear <= '0;
    end else begin
      exc_clear <= exc_clear_nxt;
      bias_clear <= bias_hit_any;
    end
  end

  property p_exc_clear;
    @(posedge mclk) disable iff (!rst_n)
      (bias_wr && exc_sel_cur[3:0] == 4'h2 && bias_wdata[2] && !bias_en[2]) |=> exc_clear[0];
  endproperty
  a_exc_clear: assert property (p_exc_clear) else $error("excitation not cleared");

  property p_bias_clear;
    @(posedge mclk) disable iff (!rst_n)
      (exc_wr && exc_sel_new[3:0] == 4'h5 && bias_en[5]) |=> bias_clear[5] ##1 !bias_clear[5];
  endproperty
  a_bias_clear: assert property (p_bias_clear) else $error("bias not cleared");
endmodule // bias_exc_guard
`default_nettype wire

// ===== tb_top.sv
/*
  Self-checking testbench for the front-end configuration register bank.
  Assumes the bank's package is compiled first; the bench plays the serial
  port, the sequencer, the bias/excitation registers and the result path.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import adc_cfg_pkg::*;
;
  logic mclk;
  logic rst_n;
  logic reg_wr;
  logic reg_wr_seq;
  logic seq_running;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic bias_wr;
  logic [BIAS_INPUTS-1:0] bias_wdata;
  logic [BIAS_INPUTS-1:0] bias_en;
  logic exc_wr;
  logic [7:0] exc_sel_new;
  logic [7:0] exc_sel_cur;
  logic [1:0] exc_clear;
  logic [BIAS_INPUTS-1:0] bias_clear;
  logic gpio_out;
  logic gpio_oe_n;
  logic gp0_out;
  logic gp0_oe_n;
  logic ext_clk;
  logic unipolar;
  logic buf_p;
  logic buf_n;
  logic [1:0] ref_pair_sel;
  logic ref_supply;
  logic ref_single_ended;
  logic bias_active;
  logic bias_div125k;
  logic bias_div20k;
  logic [1:0] burnout;
  logic [3:0] exc_level;
  logic exc_level_valid;
  logic [MUX_INPUTS-1:0] pos_in;
  logic pos_to_supply;
  logic [MUX_INPUTS-1:0] neg_in;
  logic neg_to_ground;
  logic [1:0] filter_type;
  logic [3:0] rate_select;
  logic result_valid;
  logic signed [25:0] result_raw;
  logic [23:0] result_code;
  logic result_code_valid;
  int failures = 0;
  int comparisons = 0;
  logic [3:0] c;
  logic [9:0] oh;
  // Result table: control value, raw result, expected coded output
  logic [7:0] rc [10] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h21, 8'h21, 8'h21, 8'h61, 8'h41, 8'h61};
  logic signed [25:0] rr [10] = '{26'sh0000000, -26'sh0000001, 26'sh0800000, -26'sh0800001,
    26'sh0000000, 26'sh0800000, -26'sh1000000, 26'sh0123456, -26'sh0000005, 26'sh1000000};
  logic [23:0] re [10] = '{24'h000000, 24'hFFFFFF, 24'h7FFFFF, 24'h800000, 24'h800000,
    24'hFFFFFF, 24'h000000, 24'h123456, 24'h000000, 24'hFFFFFF};

  adc_frontend_config_regs #(.RES_W(24)) i_adc_frontend_config_regs (
    .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_wr_seq(reg_wr_seq),
    .seq_running(seq_running), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .bias_wr(bias_wr), .bias_wdata(bias_wdata), .bias_en(bias_en),
    .exc_wr(exc_wr), .exc_sel_new(exc_sel_new), .exc_sel_cur(exc_sel_cur),
    .exc_clear(exc_clear), .bias_clear(bias_clear), .first_gpio_control_out(gpio_out),
    .first_gpio_control_oe_n(gpio_oe_n), .gp0_out(gp0_out), .gp0_oe_n(gp0_oe_n),
    .external_clock_select(ext_clk), .unipolar_range_select(unipolar),
    .ref_pos_buffer_enable(buf_p), .ref_neg_buffer_enable(buf_n), .ref_pair_sel(ref_pair_sel),
    .ref_supply(ref_supply), .ref_single_ended(ref_single_ended), .bias_active(bias_active),
    .bias_div125k(bias_div125k), .bias_div20k(bias_div20k), .burnout_current_level(burnout),
    .excitation_current_level(exc_level), .excitation_level_valid(exc_level_valid),
    .positive_mux_input(pos_in), .pos_to_supply(pos_to_supply), .negative_mux_input(neg_in),
    .neg_to_ground(neg_to_ground), .filter_type_select(filter_type), .rate_select(rate_select),
    .result_valid(result_valid), .result_raw(result_raw), .result_code(result_code),
    .result_code_valid(result_code_valid)
  );

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // Write, then wait until the decoded outputs have caught up
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic s);
    @(posedge mclk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr_seq = s;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_wr_seq = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask

  task automatic res(input logic signed [25:0] raw, input logic [23:0] exp);
    @(posedge mclk);
    #1;
    result_valid = 1'b1;
    result_raw = raw;
    @(posedge mclk);
    #1;
    result_valid = 1'b0;
    chk(result_code_valid, 1'b1);
    chk(result_code, exp);
  endtask

  // Clear pulses must show for exactly the cycle after the write event
  task automatic gd(input logic bw, input logic [7:0] bwd, input logic [7:0] ben,
                    input logic ew, input logic [7:0] nw, input logic [7:0] cur,
                    input logic [1:0] ee, input logic [7:0] eb);
    @(posedge mclk);
    #1;
    bias_wr = bw;
    bias_wdata = bwd;
    bias_en = ben;
    exc_wr = ew;
    exc_sel_new = nw;
    exc_sel_cur = cur;
    @(posedge mclk);
    #1;
    bias_wr = 1'b0;
    exc_wr = 1'b0;
    chk(exc_clear, ee);
    chk(bias_clear, eb);
    @(posedge mclk);
    #1;
    chk({exc_clear, bias_clear}, 10'h000);
  endtask

  task automatic conclude();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_wr_seq, seq_running, reg_rd, bias_wr, exc_wr, result_valid} = 7'h00;
    {reg_addr, reg_wdata, bias_wdata, bias_en, exc_sel_new, exc_sel_cur} = 48'h0;
    gpio_out = 1'b1;
    gpio_oe_n = 1'b0;
    result_raw = 26'sh0000000;
    repeat (10) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    // Reset values
    rd(FILTER_ADDR, 8'h00);
    rd(CTRL_ADDR, 8'h01);
    rd(SOURCE_ADDR, 8'h00);
    rd(MUX_ADDR, 8'hFF);
    chk({ext_clk, unipolar, buf_p, buf_n, ref_pair_sel}, 6'h01);
    chk({bias_active, burnout, exc_level}, 7'h40);
    chk({pos_in, neg_in}, 20'h0);
    // Reference select and buffer enables, every code
    for (int i = 0; i < 8; i++) begin
      wr(CTRL_ADDR, {3'h0, i[0], i[1], i[2:0]}, 1'b0);
      chk({buf_p, buf_n}, {i[0], i[1]});
      chk(ref_pair_sel, i[1:0]);
      chk({ref_supply, ref_single_ended}, {(i == 3 || i == 7), (i >= 4 && i <= 6)});
    end
    // External clock overrides the pin's own drive
    wr(CTRL_ADDR, 8'hC0, 1'b0);
    chk({ext_clk, unipolar, gp0_oe_n}, 3'h7);
    wr(CTRL_ADDR, 8'h20, 1'b0);
    chk({ext_clk, unipolar, gp0_oe_n, gp0_out}, 4'h1);
    // Sequencer write during a sequence keeps the clock select
    seq_running = 1'b1;
    wr(CTRL_ADDR, 8'hA5, 1'b1);
    rd(CTRL_ADDR, 8'h25);
    wr(CTRL_ADDR, 8'h80, 1'b0);
    wr(CTRL_ADDR, 8'h02, 1'b1);
    rd(CTRL_ADDR, 8'h82);
    chk(ext_clk, 1'b1);
    seq_running = 1'b0;
    wr(CTRL_ADDR, 8'h25, 1'b1);
    rd(CTRL_ADDR, 8'h25);
    // Source fields over all codes
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      wr(SOURCE_ADDR, {c[1:0], c[1:0], c}, 1'b0);
      chk({bias_active, bias_div125k, bias_div20k}, {c[1:0] == 0, c[1:0] == 1, c[1] == 1});
      chk(burnout, c[1:0]);
      chk({exc_level, exc_level_valid}, {c, !(c == 4'hC || c == 4'hD)});
      rd(SOURCE_ADDR, {c[1:0], c[1:0], c});
    end
    // Mux selects over all codes
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      oh = (i < 10) ? (10'h001 << i) : 10'h000;
      wr(MUX_ADDR, {c, c}, 1'b0);
      chk({pos_in, pos_to_supply}, {oh, i == 10});
      chk({neg_in, neg_to_ground}, {oh, i == 10});
      rd(MUX_ADDR, {c, c});
    end
    // Filter types; top bits never stick
    for (int i = 0; i < 4; i++) begin
      wr(FILTER_ADDR, {2'h3, i[1:0], 4'hA}, 1'b0);
      chk({filter_type, rate_select}, {i[1:0], 4'hA});
      rd(FILTER_ADDR, {2'h0, i[1:0], 4'hA});
    end
    // Unmapped place reads zero and a write there leaves the control register unchanged
    wr(8'h20, 8'h55, 1'b0);
    rd(8'h20, 8'h00);
    rd(CTRL_ADDR, 8'h25);
    // Read straight after a write returns the new value
    @(posedge mclk);
    #1;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, CTRL_ADDR, 8'h5A};
    @(posedge mclk);
    #1;
    {reg_wr, reg_rd} = 2'b01;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    chk(reg_rdata, 8'h5A);
    // Result coding and saturation in each range and format
    for (int i = 0; i < 10; i++) begin
      wr(CTRL_ADDR, rc[i], 1'b0);
      res(rr[i], re[i]);
    end
    rd(CTRL_ADDR, 8'h61);
    // Bias against excitation on one input
    gd(1'b1, 8'h04, 8'h00, 1'b0, 8'hFF, 8'hF2, 2'h1, 8'h00);
    gd(1'b1, 8'h04, 8'h04, 1'b0, 8'hFF, 8'hF2, 2'h0, 8'h00);
    gd(1'b1, 8'h08, 8'h00, 1'b0, 8'hFF, 8'h3F, 2'h2, 8'h00);
    gd(1'b0, 8'h00, 8'h20, 1'b1, 8'h5F, 8'hFF, 2'h0, 8'h20);
    gd(1'b0, 8'h00, 8'h20, 1'b1, 8'hF5, 8'hFF, 2'h0, 8'h20);
    gd(1'b0, 8'h00, 8'hFF, 1'b1, 8'hF9, 8'hFF, 2'h0, 8'h00);
    // Second reset in mid-run
    wr(CTRL_ADDR, 8'hFF, 1'b0);
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk({ext_clk, gp0_oe_n}, 2'h1);
    rst_n = 1'b1;
    rd(CTRL_ADDR, 8'h01);
    chk({ext_clk, gp0_oe_n}, 2'h0);
    conclude();
  end

  // Tests take about 400 cycles; cut off well beyond that
  initial begin
    #100000;
    failures++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
